// >>> bss_params.svh
// Purpose: constants of the boot source selector
// Assumes: included by its bare name; definitions only
// Notes:   offsets are byte addresses on the register bus
//
// Behaviour
// - after any reset instruction fetch starts in the internal boot ROM, and this block tells that code what to load.
// - the boot ROM window that holds the reset code is 64 kilobytes.
// - an unprogrammed or all-zero boot source code hands the choice to the four strap pins.
// - strap levels are those held at reset, and later pin changes leave the choice alone.
// - strap code is boot_pin_3 down to boot_pin_0, high is one, and straps 0000 to 1000 equal fuse codes 0001 to 1001.
// - fuse 0001 or strap 0000 boots from serial port zero.
// - fuse 0010 boots from quad serial flash on the quad flash port.
// - fuse 0011, 0100 and 0101 boot from static memory on chip select zero with 8, 16 and 32 data bits.
// - fuse 0110 and 0111 boot from usb port zero and one, and 1000 from serial flash on sync serial port zero.
// - fuse 1001 or strap 1000 boots from serial port three.
// - at reset the pin functions for the chosen serial flash path are set, differently for quad flash and sync serial.
`ifndef BSS_PARAMS_SVH
`define BSS_PARAMS_SVH

// --------------------------------------------------------------------------
// boot source codes (fuse encoding)
// --------------------------------------------------------------------------
`define BSS_SRC_NONE     4'h0
`define BSS_SRC_SER0     4'h1
`define BSS_SRC_QFLASH   4'h2
`define BSS_SRC_SMEM8    4'h3
`define BSS_SRC_SMEM16   4'h4
`define BSS_SRC_SMEM32   4'h5
`define BSS_SRC_USB_PORT_ZERO     4'h6
`define BSS_SRC_USB_PORT_ONE     4'h7
`define BSS_SRC_SSPFL    4'h8
`define BSS_SRC_SER3     4'h9
`define BSS_STRAP_MAX    4'h8
`define BSS_NUM_SRC      9

// --------------------------------------------------------------------------
// boot rom window
// --------------------------------------------------------------------------
`define BSS_ROM_KBYTES   64
`define BSS_ROM_BYTES    (`BSS_ROM_KBYTES * 1024)

// --------------------------------------------------------------------------
// pin function codes for the serial flash pin group
// --------------------------------------------------------------------------
`define BSS_PF_GPIO      3'h0
`define BSS_PF_QFLASH    3'h3
`define BSS_PF_SSP       3'h5
`define BSS_SSP_PIN_MASK 6'h39

// --------------------------------------------------------------------------
// register map
// --------------------------------------------------------------------------
`define BSS_OFF_CTRL     5'h00
`define BSS_OFF_STATUS   5'h04
`define BSS_OFF_CODES    5'h08
`define BSS_OFF_PINFUNC  5'h0C
`define BSS_OFF_ROMSIZE  5'h10
`define BSS_CTRL_RELEASE 0
`define BSS_CTRL_PINEN   1
`define BSS_CTRL_RST     2'h2

`endif

// >>> bss_pkg.sv
// Purpose: types and shared decoding of the boot source selector
// Assumes: bss_params.svh on the include path
// Notes:   none
`include "bss_params.svh"

package bss_pkg;

   typedef enum logic [1:0] {ST_CAPTURE, ST_DECIDE, ST_BOOT, ST_RUN} bss_state_t;

   typedef struct packed {
      bss_state_t  st;
      logic        prog;
      logic [3:0]  fuse;
      logic [3:0]  code;
      logic        strap_mode;
      logic        valid;
      logic [1:0]  ctrl;
      logic        a_sel;
      logic        a_wr;
      logic [4:0]  a_addr;
      logic [31:0] rdata;
   } bss_top_st_t;

   // fuse code wins unless unprogrammed or zero; straps 0 to 8 shift up by one, higher straps give none
   function automatic logic [3:0] bss_norm_code(input logic prog, input logic [3:0] fuse,
                                                input logic [3:0] strap);
      logic [3:0] c;
      c = fuse;
      if (!prog || fuse == `BSS_SRC_NONE)
      begin
         c = (strap <= `BSS_STRAP_MAX) ? 4'(strap + 4'h1) : `BSS_SRC_NONE;
      end
      return c;
   endfunction : bss_norm_code

   function automatic logic bss_code_ok(input logic [3:0] c);
      return (c >= `BSS_SRC_SER0) && (c <= `BSS_SRC_SER3);
   endfunction : bss_code_ok

endpackage : bss_pkg

// >>> bss_strap_latch.sv
// Purpose: catch the boot strap pins once after reset release
// Assumes: pins synchronous to hclk and stable around reset release
// Notes:   capture happens at the first edge after release only
`timescale 1ns/1ns
`default_nettype none

module bss_strap_latch
   import bss_pkg::*;
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic [3:0] boot_pin,
   output logic [3:0]      strap_code,
   output logic            strap_done
);

   typedef struct packed {
      logic       done;
      logic [3:0] code;
   } bss_latch_st_t;

   bss_latch_st_t s_r;
   bss_latch_st_t s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      if (!s_r.done)
      begin
         s_nxt.code = boot_pin;
         s_nxt.done = 1'b1;
      end
   end

   // constant under reset; later pin moves never reach the code
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign strap_code = s_r.code;
   assign strap_done = s_r.done;

endmodule : bss_strap_latch

`default_nettype wire

// >>> bss_pin_cfg.sv
// Purpose: pin function assignment for the serial flash boot paths
// Assumes: code is final in the cycle in which apply is high
// Notes:   pins not used by the chosen path keep the gpio function
`timescale 1ns/1ns
`default_nettype none

module bss_pin_cfg
   import bss_pkg::*;
#(
   parameter int N_PINS = 6,
   parameter int FW     = 3
)
(
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  apply,
   input  wire logic [3:0]            code,
   output logic [N_PINS*FW-1:0]       pin_func,
   output logic [N_PINS-1:0]          pin_ovr
);

   generate
      if (N_PINS != 6 || FW != 3)
      begin : g_chk
         $error("bss_pin_cfg serves exactly six pins of three-bit function");
      end
   endgenerate

   typedef struct packed {
      logic [N_PINS*FW-1:0] func;
      logic [N_PINS-1:0]    ovr;
   } bss_pin_st_t;

   localparam logic [5:0] SSP_MASK = `BSS_SSP_PIN_MASK;

   bss_pin_st_t s_r;
   bss_pin_st_t s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      if (apply)
      begin
         s_nxt.func = '0;
         s_nxt.ovr  = '0;
         for (int i = 0; i < N_PINS; i++)
         begin
            if (code == `BSS_SRC_QFLASH)
            begin
               s_nxt.func[i*FW +: FW] = `BSS_PF_QFLASH;
               s_nxt.ovr[i]           = 1'b1;
            end
            else if (code == `BSS_SRC_SSPFL && SSP_MASK[i])
            begin
               s_nxt.func[i*FW +: FW] = `BSS_PF_SSP;
               s_nxt.ovr[i]           = 1'b1;
            end
            else
            begin
               s_nxt.func[i*FW +: FW] = `BSS_PF_GPIO;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign pin_func = s_r.func;
   assign pin_ovr  = s_r.ovr;

endmodule : bss_pin_cfg

`default_nettype wire

// >>> bss_top.sv
// Purpose: boot source selector with AHB-Lite status and control
// Assumes: fuse inputs valid from reset release; single slave on its bus
// Notes:   zero wait states; read data registered in the data phase
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module bss_top
   import bss_pkg::*;
#(
   parameter logic [31:0] ROM_BASE = 32'h0000_0000
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // fuses and straps
   input  wire logic        otp_programmed,
   input  wire logic [3:0]  boot_source_code,
   input  wire logic        boot_pin_3,
   input  wire logic        boot_pin_2,
   input  wire logic        boot_pin_1,
   input  wire logic        boot_pin_0,
   // boot rom fetch
   output logic             rom_fetch,
   output logic [31:0]      rom_base,
   output logic [31:0]      rom_mask,
   // selection result
   output logic             sel_done,
   output logic             sel_valid,
   output logic             sel_invalid,
   output logic             sel_strap_mode,
   output logic [3:0]       sel_code,
   output logic             serial_port_zero_boot,
   output logic             quad_flash_port_boot,
   output logic             static_memory_port_boot,
   output logic [1:0]       static_memory_width,
   output logic             usb_port_zero_boot,
   output logic             usb_port_one_boot,
   output logic             sync_serial_port_zero_boot,
   output logic             serial_port_three_boot,
   // serial flash pin group
   output logic [17:0]      flash_pin_func,
   output logic [5:0]       flash_pin_ovr
);

   localparam logic [31:0] ROM_BYTES = 32'(`BSS_ROM_BYTES);

   // -----------------------------------------------------------------------
   // strap capture and pin function
   // -----------------------------------------------------------------------
   logic [3:0]  strap_code;
   logic        strap_done;
   logic        pin_apply;
   logic [17:0] pin_func;
   logic [5:0]  pin_ovr;
   logic [3:0]  dec_code;

   bss_top_st_t s_r;
   bss_top_st_t s_nxt;

   bss_strap_latch u_strap
   (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .boot_pin   ({boot_pin_3, boot_pin_2, boot_pin_1, boot_pin_0}),
      .strap_code (strap_code),
      .strap_done (strap_done)
   );

   // the code being decided, so pin functions land on the same edge as the choice
   assign dec_code = bss_norm_code(s_r.prog, s_r.fuse, strap_code);

   // applied once per reset, when the choice is made
   assign pin_apply = (s_r.st == ST_DECIDE) && s_r.ctrl[`BSS_CTRL_PINEN];

   bss_pin_cfg #(
      .N_PINS (6),
      .FW     (3)
   ) u_pin
   (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .apply    (pin_apply),
      .code     (dec_code),
      .pin_func (pin_func),
      .pin_ovr  (pin_ovr)
   );

   // -----------------------------------------------------------------------
   // register read mux
   // -----------------------------------------------------------------------
   function automatic logic [31:0] rd_word(input logic [4:0] a, input bss_top_st_t s,
                                           input logic [3:0] sc, input logic [17:0] pf);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (a)
         `BSS_OFF_CTRL:    w = {30'h0, s.ctrl};
         `BSS_OFF_STATUS:  w = {23'h0, s.code, (s.st == ST_BOOT), s.strap_mode,
                                (s.st != ST_CAPTURE && s.st != ST_DECIDE) && !s.valid,
                                s.valid, (s.st == ST_BOOT || s.st == ST_RUN)};
         `BSS_OFF_CODES:   w = {23'h0, s.prog, sc, s.fuse};
         `BSS_OFF_PINFUNC: w = {14'h0, pf};
         `BSS_OFF_ROMSIZE: w = ROM_BYTES;
         default:          w = 32'h0000_0000;
      endcase
      return w;
   endfunction : rd_word

   // -----------------------------------------------------------------------
   // state update
   // -----------------------------------------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      case (s_r.st)
         ST_CAPTURE:
         begin
            s_nxt.prog = otp_programmed;
            s_nxt.fuse = boot_source_code;
            if (strap_done)
            begin
               s_nxt.st = ST_DECIDE;
            end
         end
         ST_DECIDE:
         begin
            s_nxt.code       = dec_code;
            s_nxt.strap_mode = !s_r.prog || s_r.fuse == `BSS_SRC_NONE;
            s_nxt.valid      = bss_code_ok(dec_code);
            s_nxt.st         = ST_BOOT;
         end
         ST_BOOT:
         begin
            if (s_r.ctrl[`BSS_CTRL_RELEASE])
            begin
               s_nxt.st = ST_RUN;
            end
         end
         ST_RUN:
         begin
            s_nxt.st = ST_RUN;
         end
         default:
         begin
            s_nxt.st = ST_CAPTURE;
         end
      endcase

      // data phase of a write
      if (s_r.a_sel && s_r.a_wr && s_r.a_addr == `BSS_OFF_CTRL)
      begin
         s_nxt.ctrl = hwdata[1:0];
      end

      // address phase
      s_nxt.a_sel = 1'b0;
      if (hready)
      begin
         s_nxt.a_sel  = hsel && htrans[1];
         s_nxt.a_wr   = hwrite;
         s_nxt.a_addr = haddr[4:0] & 5'h1C;
         if (hsel && htrans[1] && !hwrite)
         begin
            s_nxt.rdata = (haddr[31:5] == 27'h0) ?
                          rd_word(haddr[4:0] & 5'h1C, s_r, strap_code, pin_func) : 32'h0000_0000;
         end
      end
      // unmapped high addresses must not alias onto the control word
      if (hready && haddr[31:5] != 27'h0)
      begin
         s_nxt.a_addr = 5'h1C;
      end
   end

   // hsize is always a word here; narrower writes are taken as whole words
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_r      <= '0;
         s_r.st   <= ST_CAPTURE;
         s_r.ctrl <= `BSS_CTRL_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // -----------------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------------
   assign hrdata    = s_r.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // fetch stays in the rom until software releases it
   assign rom_fetch = (s_r.st != ST_RUN);
   assign rom_base  = ROM_BASE;
   assign rom_mask  = ROM_BYTES - 32'h0000_0001;

   assign sel_done       = (s_r.st == ST_BOOT) || (s_r.st == ST_RUN);
   assign sel_valid      = sel_done && s_r.valid;
   assign sel_invalid    = sel_done && !s_r.valid;
   assign sel_strap_mode = s_r.strap_mode;
   assign sel_code       = s_r.code;

   assign serial_port_zero_boot      = sel_valid && s_r.code == `BSS_SRC_SER0;
   assign quad_flash_port_boot       = sel_valid && s_r.code == `BSS_SRC_QFLASH;
   assign static_memory_port_boot    = sel_valid && (s_r.code == `BSS_SRC_SMEM8 ||
                                                     s_r.code == `BSS_SRC_SMEM16 ||
                                                     s_r.code == `BSS_SRC_SMEM32);
   // 0: 8 bits, 1: 16 bits, 2: 32 bits
   assign static_memory_width        = !static_memory_port_boot ? 2'h0 :
                                       2'(s_r.code - `BSS_SRC_SMEM8);
   assign usb_port_zero_boot         = sel_valid && s_r.code == `BSS_SRC_USB_PORT_ZERO;
   assign usb_port_one_boot          = sel_valid && s_r.code == `BSS_SRC_USB_PORT_ONE;
   assign sync_serial_port_zero_boot = sel_valid && s_r.code == `BSS_SRC_SSPFL;
   assign serial_port_three_boot     = sel_valid && s_r.code == `BSS_SRC_SER3;

   assign flash_pin_func = pin_func;
   assign flash_pin_ovr  = pin_ovr;

endmodule : bss_top

`default_nettype wire

// >>> bss_properties.sv
// Purpose: port-level properties of the boot source selector
// Assumes: bound to bss_top; pin apply enable left at its reset value
// Notes:   one clock domain, so default clocking and disable
`timescale 1ns/1ns
`default_nettype none

module bss_properties
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        rom_fetch,
   input wire logic        sel_done,
   input wire logic        sel_valid,
   input wire logic        sel_invalid,
   input wire logic [3:0]  sel_code,
   input wire logic        serial_port_zero_boot,
   input wire logic        quad_flash_port_boot,
   input wire logic        static_memory_port_boot,
   input wire logic [1:0]  static_memory_width,
   input wire logic        usb_port_zero_boot,
   input wire logic        usb_port_one_boot,
   input wire logic        sync_serial_port_zero_boot,
   input wire logic        serial_port_three_boot,
   input wire logic [17:0] flash_pin_func
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic [6:0] boots;
   logic [6:0] exp_boots;
   assign boots = {serial_port_zero_boot, quad_flash_port_boot, static_memory_port_boot, usb_port_zero_boot,
                   usb_port_one_boot, sync_serial_port_zero_boot, serial_port_three_boot};
   always_comb
   begin
      case (sel_code)
         4'h1: exp_boots = 7'h40;
         4'h2: exp_boots = 7'h20;
         4'h3, 4'h4, 4'h5: exp_boots = 7'h10;
         4'h6: exp_boots = 7'h08;
         4'h7: exp_boots = 7'h04;
         4'h8: exp_boots = 7'h02;
         4'h9: exp_boots = 7'h01;
         default: exp_boots = 7'h00;
      endcase
   end

   // --------------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------------
   bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not zero-wait okay");
   fetch_rom_a: assert property ($rose(sel_done) |-> rom_fetch) else $error("no rom fetch at choice");
   release_order_a: assert property ($fell(rom_fetch) |-> $past(sel_done, 2)) else $error("early release");
   choice_held_a: assert property (sel_done |=> sel_done && $stable(sel_code) && $stable(boots))
      else $error("boot choice moved");
   one_source_a: assert property (sel_valid |-> $onehot(boots)) else $error("not one boot source");
   no_source_a: assert property (!sel_valid |-> boots == 7'h00) else $error("source without valid");
   invalid_code_a: assert property (sel_done |-> sel_invalid == !(sel_code inside {[4'h1:4'h9]}))
      else $error("invalid flag wrong");
   source_map_a: assert property (sel_valid |-> boots == exp_boots) else $error("source map wrong");
   mem_width_a: assert property (static_memory_port_boot |-> static_memory_width == 2'(sel_code - 4'h3))
      else $error("static width wrong");
   pin_func_a: assert property ($rose(sel_done) |=> flash_pin_func == (quad_flash_port_boot ? 18'h1B6DB :
      sync_serial_port_zero_boot ? 18'h2DA05 : 18'h00000)) else $error("pin functions wrong");

   cover property (sel_valid && quad_flash_port_boot);
   cover property (sel_valid && sync_serial_port_zero_boot);
   cover property (sel_invalid);
   cover property ($fell(rom_fetch));
endmodule : bss_properties

bind bss_top bss_properties u_props (.hclk, .hresetn, .hreadyout, .hresp, .rom_fetch, .sel_done, .sel_valid,
   .sel_invalid, .sel_code, .serial_port_zero_boot, .quad_flash_port_boot, .static_memory_port_boot,
   .static_memory_width, .usb_port_zero_boot, .usb_port_one_boot, .sync_serial_port_zero_boot,
   .serial_port_three_boot, .flash_pin_func);

`default_nettype wire

// >>> bss_boot_strap_model.sv
// Purpose: fuses and strap pins seen by the boot source selector
// Assumes: bench sets the reset-time values before reset release
// Notes:   fuse code and pins wander once the capture window is over; the programmed flag holds
`timescale 1ns/1ns
`default_nettype none

module bss_boot_strap_model
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       prog_cfg,
   input  wire logic [3:0] fuse_cfg,
   input  wire logic [3:0] pins_cfg,
   input  wire logic [7:0] late_cfg,
   output logic            otp_programmed,
   output logic [3:0]      boot_source_code,
   output logic [3:0]      boot_pins
);
   logic [1:0] age_r;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         age_r <= 2'h0;
      else if (age_r != 2'h3)
         age_r <= age_r + 2'h1;
   end

   // nothing guarantees the pins after capture, so they wander on purpose
   always_comb
   begin
      otp_programmed = prog_cfg;
      {boot_source_code, boot_pins} = (age_r == 2'h3) ? late_cfg : {fuse_cfg, pins_cfg};
   end
endmodule : bss_boot_strap_model

`default_nettype wire

// >>> test_boot_source_select.sv
// Purpose: self-checking bench of the boot source selector
// Assumes: zero-wait slave; status final three edges after release
// Notes:   every case runs under a fresh reset
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, ex, got) \
   begin \
      checks++; \
      if ((got) !== (ex)) \
      begin \
         mismatches++; \
         $display("mismatch %s exp %0h got %0h", nm, ex, got); \
      end \
   end

module test_boot_source_select;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, prog_cfg, otp, rom_fetch;
   logic [1:0]  htrans, smw;
   logic [31:0] haddr, hwdata, hrdata, seed;
   logic [3:0]  fuse_cfg, pins_cfg, bsc, bpins, sel_code;
   logic [7:0]  late_cfg;
   logic        done, valid, invalid, strap, s0, qf, sm, u0, u1, sp, s3;
   logic [17:0] pfunc;
   logic        hresp_w;
   logic [5:0]  povr;
   logic [31:0] rbase, rmask;
   int          mismatches, checks;

   assign hready = hreadyout;

   bss_boot_strap_model u_far (.hclk, .hresetn, .prog_cfg, .fuse_cfg, .pins_cfg, .late_cfg,
      .otp_programmed(otp), .boot_source_code(bsc), .boot_pins(bpins));

   bss_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready, .hwdata, .hrdata,
      .hreadyout, .hresp(hresp_w), .otp_programmed(otp), .boot_source_code(bsc), .boot_pin_3(bpins[3]),
      .boot_pin_2(bpins[2]), .boot_pin_1(bpins[1]), .boot_pin_0(bpins[0]), .rom_fetch, .rom_base(rbase),
      .rom_mask(rmask), .sel_done(done), .sel_valid(valid), .sel_invalid(invalid), .sel_strap_mode(strap),
      .sel_code, .serial_port_zero_boot(s0), .quad_flash_port_boot(qf), .static_memory_port_boot(sm),
      .static_memory_width(smw), .usb_port_zero_boot(u0), .usb_port_one_boot(u1),
      .sync_serial_port_zero_boot(sp), .serial_port_three_boot(s3), .flash_pin_func(pfunc), .flash_pin_ovr(povr));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic logic [6:0] exp_boots(input int c);
      case (c)
         1: return 7'h40;
         2: return 7'h20;
         3, 4, 5: return 7'h10;
         6: return 7'h08;
         7: return 7'h04;
         8: return 7'h02;
         9: return 7'h01;
         default: return 7'h00;
      endcase
   endfunction : exp_boots

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim

   // single transfer; held until hready is seen high
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : ahb

   task automatic run_case(input logic p, input logic [3:0] f, input logic [3:0] s);
      int          c;
      logic        st, v;
      logic [31:0] rd;
      st = (p == 1'b0 || f == 4'h0);
      c = !st ? f : (s <= 4'h8) ? s + 1 : 0;
      v = (c >= 1 && c <= 9);
      hresetn <= 1'b0;
      prog_cfg <= p;
      fuse_cfg <= f;
      pins_cfg <= s;
      late_cfg <= 8'(rnd());
      repeat (5) @(posedge hclk);
      `CHK("rstout", 2'b10, {rom_fetch, done})
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      // look at settled outputs, away from the launching edge
      @(negedge hclk);
      `CHK("code", 4'(c), sel_code)
      `CHK("strap", st, strap)
      `CHK("valid", {v, !v}, {valid, invalid})
      `CHK("boots", exp_boots(c), {s0, qf, sm, u0, u1, sp, s3})
      `CHK("width", (c >= 3 && c <= 5) ? 2'(c - 3) : 2'h0, smw)
      `CHK("pinfunc", c == 2 ? 18'h1B6DB : c == 8 ? 18'h2DA05 : 18'h00000, pfunc)
      `CHK("pinovr", c == 2 ? 6'h3F : c == 8 ? 6'h39 : 6'h00, povr)
      `CHK("fetch", 1'b1, rom_fetch)
      `CHK("rombase", 32'h00000000, rbase)
      `CHK("rommask", 32'h0000FFFF, rmask)
      `CHK("okay", 1'b0, hresp_w)
      @(posedge hclk);
      ahb(1'b0, 32'h04, 32'h0, rd);
      `CHK("status", {23'h0, 4'(c), 1'b1, st, !v, v, 1'b1}, rd)
      ahb(1'b0, 32'h08, 32'h0, rd);
      `CHK("codes", {23'h0, p, s, f}, rd)
      ahb(1'b0, 32'h10, 32'h0, rd);
      `CHK("romsize", 32'h00010000, rd)
      ahb(1'b1, 32'h14, rnd(), rd);
      ahb(1'b0, 32'h14, 32'h0, rd);
      `CHK("unmapped", 32'h0, rd)
      ahb(1'b1, 32'h00, 32'h3, rd);
      repeat (2) @(posedge hclk);
      `CHK("release", 1'b0, rom_fetch)
   endtask : run_case

   initial
   begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   initial
   begin
      #40000;
      mismatches++;
      end_sim();
   end

   initial
   begin
      logic [31:0] r;
      seed = 32'h501F;
      {hresetn, hsel, hwrite, prog_cfg} = 4'h0;
      {htrans, haddr, hwdata, fuse_cfg, pins_cfg, late_cfg} = '0;
      mismatches = 0;
      checks = 0;
      @(posedge hclk);
      // fuse codes 0..15, then every strap code with random programming state
      for (int i = 0; i < 16; i++)
         run_case(1'b1, 4'(i), 4'(rnd()));
      for (int i = 0; i < 16; i++)
      begin
         r = rnd();
         run_case(r[0], r[0] ? 4'h0 : r[7:4], 4'(i));
      end
      end_sim();
   end
endmodule : test_boot_source_select

`default_nettype wire
